// [core/lpc_pkg.sv]
// Purpose: Shared constants and types for the lighting program configuration block
// Assumes: 32-bit APB, register index times four gives the byte address
// Notes:   Timing figures in their own units, cycle counts derived from them
package lpc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int NUM_ENG    = 3;
  localparam int NUM_OUT    = 10;
  localparam int MEM_WORDS  = 96;
  localparam int PAGE_WORDS = 16;
  localparam int NUM_PAGES  = 6;
  localparam int WORD_W     = 16;
  localparam int ADDR_W     = 7;
  localparam int PAGE_W     = 3;
  localparam int LEVEL_W    = 8;
  localparam int CNT_W      = 14;
  localparam int PADDR_W    = 12;

  ////////////////////////////////////////////////////////////////////////////////
  // Register indices (byte address = index * 4)
  localparam logic [7:0] IDX_OP_MODE       = 8'h01;
  localparam logic [7:0] IDX_CLK_CFG       = 8'h36;
  localparam logic [7:0] IDX_VARS          = 8'h44;
  localparam logic [7:0] IDX_ENG1_START    = 8'h4c;
  localparam logic [7:0] IDX_ENG2_START    = 8'h4d;
  localparam logic [7:0] IDX_ENG3_START    = 8'h4e;
  localparam logic [7:0] IDX_PAGE_SEL      = 8'h4f;
  localparam logic [7:0] IDX_MEM_BASE      = 8'h50;
  localparam logic [7:0] IDX_ENG1_MAP_HIGH = 8'h70;
  localparam logic [7:0] IDX_ENG1_MAP_LOW  = 8'h71;
  localparam logic [7:0] IDX_ENG2_MAP_HIGH = 8'h72;
  localparam logic [7:0] IDX_ENG2_MAP_LOW  = 8'h73;
  localparam logic [7:0] IDX_ENG3_MAP_HIGH = 8'h74;
  localparam logic [7:0] IDX_ENG3_MAP_LOW  = 8'h75;
  localparam logic [7:0] IDX_ENG1_MAP_CFG  = 8'h78;
  localparam logic [7:0] IDX_ENG2_MAP_CFG  = 8'h79;
  localparam logic [7:0] IDX_ENG3_MAP_CFG  = 8'h7a;

  ////////////////////////////////////////////////////////////////////////////////
  // Fields
  localparam int MAP_HIGH_GEN_BIT  = 7;
  localparam int MAP_HIGH_NINE_BIT = 0;
  localparam int OUT_GEN_PIN       = 9;
  localparam int OUT_NINE          = 8;
  localparam int MODE_W           = 2;
  localparam logic [1:0] MODE_DISABLED = 2'h0;
  localparam logic [1:0] MODE_LOAD     = 2'h1;
  localparam logic [1:0] MODE_RUN      = 2'h2;
  localparam logic [1:0] MODE_HOLD     = 2'h3;
  localparam logic [7:0] LEVEL_MAX     = 8'hff;

  ////////////////////////////////////////////////////////////////////////////////
  // Instruction encodings
  localparam logic [7:0] OPC_SETPWM_HI   = 8'h40;
  localparam logic [7:0] OPC_VAR_HI      = 8'h84;
  localparam logic [1:0] OPC_VAR_RAMP_MD = 2'h0;
  localparam logic [5:0] OPC_VAR_SET_MD  = 6'h18;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_HZ     = 25_000_000;
  localparam int ENG_CLK_HZ = 32_700;
  localparam int ENG_DIV    = CLK_HZ / ENG_CLK_HZ;

  typedef enum logic [1:0] {
    LPC_OP_NOP,
    LPC_OP_RAMP,
    LPC_OP_WAIT,
    LPC_OP_SETPWM
  } lpc_op_e;

  typedef struct packed {
    logic [ADDR_W-1:0]  pc;
    logic               busy;
    logic               ramp;
    logic               sign;
    logic [CNT_W-1:0]   cnt;
    logic [CNT_W-1:0]   period;
    logic [7:0]         steps;
    logic [LEVEL_W-1:0] level;
  } lpc_eng_s;

endpackage

// [core/lpc_decode.sv]
// Purpose: Decode one 16-bit program word into ramp, wait and set-level fields
// Assumes: Purely combinational; variable operands are resolved by the caller
// Notes:   Words outside the three output operations decode as no-operation
`timescale 1ns/10ps
module lpc_decode (
  input  wire logic [15:0]     i_word,
  output lpc_pkg::lpc_op_e     o_op,
  output logic                 o_prescale,
  output logic                 o_sign,
  output logic [4:0]           o_time,
  output logic [7:0]           o_incr,
  output logic [7:0]           o_pwm,
  output logic                 o_use_var,
  output logic [1:0]           o_var_time,
  output logic [1:0]           o_var_val
);

  always_comb begin
    o_op       = lpc_pkg::LPC_OP_NOP;
    o_prescale = i_word[14];
    o_sign     = i_word[8];
    o_time     = i_word[13:9];
    o_incr     = i_word[7:0];
    o_pwm      = i_word[7:0];
    o_use_var  = 1'b0;
    o_var_time = i_word[3:2];
    o_var_val  = i_word[1:0];
    // Set-level must win over ramp: its upper byte is also a legal ramp form
    if (i_word[15:8] == lpc_pkg::OPC_SETPWM_HI) begin
      o_op = lpc_pkg::LPC_OP_SETPWM;
    end else if (!i_word[15]) begin
      o_op = (i_word[7:0] == 8'h00) ? lpc_pkg::LPC_OP_WAIT : lpc_pkg::LPC_OP_RAMP;
    end else if (i_word[15:8] == lpc_pkg::OPC_VAR_HI) begin
      if (i_word[7:2] == lpc_pkg::OPC_VAR_SET_MD) begin
        o_op      = lpc_pkg::LPC_OP_SETPWM;
        o_use_var = 1'b1;
      end else if (i_word[7:6] == lpc_pkg::OPC_VAR_RAMP_MD) begin
        o_op       = lpc_pkg::LPC_OP_RAMP;
        o_use_var  = 1'b1;
        o_prescale = i_word[5];
        o_sign     = i_word[4];
      end
    end
  end

endmodule // lpc_decode

// [core/lpc_top.sv]
// Purpose: Program memory, start addresses, output mapping and three execution engines
// Assumes: APB slave at 25 MHz, external engine clock arrives asynchronously on a pin
// Notes:   One answer cycle after setup; program words reachable only in load mode
`timescale 1ns/10ps

module lpc_top #(
  parameter int ENG_DIV        = lpc_pkg::ENG_DIV,
  parameter int PRESCALE_SHORT = 16,
  parameter int PRESCALE_LONG  = 512
) (
  input  wire logic                         i_clk,
  input  wire logic                         i_rst_n,
  input  wire logic                         i_psel,
  input  wire logic                         i_penable,
  input  wire logic                         i_pwrite,
  input  wire logic [lpc_pkg::PADDR_W-1:0]  i_paddr,
  input  wire logic [31:0]                  i_pwdata,
  output logic      [31:0]                  o_prdata,
  output logic                              o_pready,
  output logic                              o_pslverr,
  input  wire logic                         i_ext_clk,
  output logic [lpc_pkg::NUM_OUT*lpc_pkg::LEVEL_W-1:0] o_out_level
);

  localparam int NE  = lpc_pkg::NUM_ENG;
  localparam int NO  = lpc_pkg::NUM_OUT;
  localparam int DVW = $clog2(ENG_DIV + 1);
  localparam int CNT_W_L  = lpc_pkg::CNT_W;
  localparam int ADDR_W_L = lpc_pkg::ADDR_W;

  // Read-only high view of one map: only the general output and output nine live here
  function automatic logic [31:0] map_high(input logic [NO-1:0] m);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[lpc_pkg::MAP_HIGH_GEN_BIT]  = m[lpc_pkg::OUT_GEN_PIN];
    v[lpc_pkg::MAP_HIGH_NINE_BIT] = m[lpc_pkg::OUT_NINE];
    return v;
  endfunction

  if (ENG_DIV < 2 || PRESCALE_SHORT < 1 || PRESCALE_LONG < 1 ||
      31 * PRESCALE_LONG >= (1 << lpc_pkg::CNT_W) ||
      31 * PRESCALE_SHORT >= (1 << lpc_pkg::CNT_W)) begin : g_bad_param
    $error("lpc_top: divider or prescale out of range");
  end

  typedef struct packed {
    logic [lpc_pkg::MEM_WORDS-1:0][lpc_pkg::WORD_W-1:0] mem;
    lpc_pkg::lpc_eng_s [NE-1:0]                         eng;
    logic [NE-1:0][lpc_pkg::ADDR_W-1:0]                 start;
    logic [NE-1:0][lpc_pkg::MODE_W-1:0]                 mode;
    logic [NE-1:0][NO-1:0]                              map;
    logic [3:0][7:0]                                    vars;
    logic [lpc_pkg::PAGE_W-1:0]                         page;
    logic                                               ext_sel;
    logic [DVW-1:0]                                     div;
    logic [1:0]                                         ext_sync;
    logic                                               ext_prev;
    logic [NO-1:0][lpc_pkg::LEVEL_W-1:0]                out;
    logic [31:0]                                        prdata;
    logic                                               pready;
    logic                                               pslverr;
  } lpc_state_s;

  lpc_state_s st_r;
  lpc_state_s st_nxt;

  ////////////////////////////////////////////////////////////////////////////////
  // Instruction fetch and decode, one decoder per engine

  logic [15:0]      fetch_word [NE];
  lpc_pkg::lpc_op_e d_op       [NE];
  logic             d_prescale [NE];
  logic             d_sign     [NE];
  logic [4:0]       d_time     [NE];
  logic [7:0]       d_incr     [NE];
  logic [7:0]       d_pwm      [NE];
  logic             d_use_var  [NE];
  logic [1:0]       d_var_time [NE];
  logic [1:0]       d_var_val  [NE];

  for (genvar g = 0; g < NE; g++) begin : g_eng_dec
    // Start addresses above the last word fetch an all-zero word, which decodes as a one-step wait before the engine wraps to word 0
    assign fetch_word[g] = (32'(st_r.eng[g].pc) < lpc_pkg::MEM_WORDS) ?
                           st_r.mem[st_r.eng[g].pc] : 16'h0000;
    lpc_decode u_dec (
      .i_word     (fetch_word[g]),
      .o_op       (d_op[g]),
      .o_prescale (d_prescale[g]),
      .o_sign     (d_sign[g]),
      .o_time     (d_time[g]),
      .o_incr     (d_incr[g]),
      .o_pwm      (d_pwm[g]),
      .o_use_var  (d_use_var[g]),
      .o_var_time (d_var_time[g]),
      .o_var_val  (d_var_val[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    logic                        div_tick;
    logic                        tick;
    logic                        load_any;
    logic                        wr_en;
    logic [7:0]                  idx;
    logic [31:0]                 rdata;
    logic                        hit;
    logic                        err;
    logic [lpc_pkg::ADDR_W-1:0]  mem_idx;
    logic                        mem_ok;
    logic [4:0]                  tval;
    logic [7:0]                  ival;
    logic [7:0]                  pval;
    logic [CNT_W_L-1:0]          per;
    div_tick = 1'b0;
    tick     = 1'b0;
    load_any = 1'b0;
    wr_en    = 1'b0;
    idx      = i_paddr[9:2];
    rdata    = 32'h0000_0000;
    hit      = 1'b0;
    err      = 1'b0;
    mem_idx  = '0;
    mem_ok   = 1'b0;
    tval     = '0;
    ival     = '0;
    pval     = '0;
    per      = '0;
    st_nxt   = st_r;

    // Engine clock: internal divider or synchronised external clock edge
    if (32'(st_r.div) == ENG_DIV - 1) begin
      st_nxt.div = '0;
      div_tick   = 1'b1;
    end else begin
      st_nxt.div = DVW'(st_r.div + 1'b1);
    end
    st_nxt.ext_sync = {st_r.ext_sync[0], i_ext_clk};
    st_nxt.ext_prev = st_r.ext_sync[1];
    tick = st_r.ext_sel ? (st_r.ext_sync[1] & ~st_r.ext_prev) : div_tick;

    for (int e = 0; e < NE; e++) begin
      if (st_r.mode[e] == lpc_pkg::MODE_LOAD) begin
        load_any = 1'b1;
      end
    end
    // Page 6 and 7 are refused: there is no memory behind them
    mem_ok  = load_any && (32'(st_r.page) < lpc_pkg::NUM_PAGES);
    mem_idx = ADDR_W_L'(32'(st_r.page) * lpc_pkg::PAGE_WORDS + 32'(idx[3:0]));

    // Register decode, shared by the read answer and the write
    if (i_paddr[lpc_pkg::PADDR_W-1:10] != '0) begin
      hit = 1'b0;
    end else if (idx >= lpc_pkg::IDX_MEM_BASE &&
                 idx < lpc_pkg::IDX_MEM_BASE + 8'(lpc_pkg::PAGE_WORDS)) begin
      hit   = 1'b1;
      err   = !mem_ok;
      rdata = mem_ok ? {16'h0000, st_r.mem[mem_idx]} : 32'h0000_0000;
    end else begin
      hit = 1'b1;
      case (idx)
        lpc_pkg::IDX_OP_MODE:       rdata = 32'({st_r.mode[0], st_r.mode[1], st_r.mode[2]});
        lpc_pkg::IDX_CLK_CFG:       rdata = 32'(st_r.ext_sel);
        lpc_pkg::IDX_VARS:          rdata = st_r.vars;
        lpc_pkg::IDX_ENG1_START:    rdata = 32'(st_r.start[0]);
        lpc_pkg::IDX_ENG2_START:    rdata = 32'(st_r.start[1]);
        lpc_pkg::IDX_ENG3_START:    rdata = 32'(st_r.start[2]);
        lpc_pkg::IDX_PAGE_SEL:      rdata = 32'(st_r.page);
        lpc_pkg::IDX_ENG1_MAP_HIGH: rdata = map_high(st_r.map[0]);
        lpc_pkg::IDX_ENG1_MAP_LOW:  rdata = 32'(st_r.map[0][7:0]);
        lpc_pkg::IDX_ENG2_MAP_HIGH: rdata = map_high(st_r.map[1]);
        lpc_pkg::IDX_ENG2_MAP_LOW:  rdata = 32'(st_r.map[1][7:0]);
        lpc_pkg::IDX_ENG3_MAP_HIGH: rdata = map_high(st_r.map[2]);
        lpc_pkg::IDX_ENG3_MAP_LOW:  rdata = 32'(st_r.map[2][7:0]);
        lpc_pkg::IDX_ENG1_MAP_CFG:  rdata = 32'(st_r.map[0]);
        lpc_pkg::IDX_ENG2_MAP_CFG:  rdata = 32'(st_r.map[1]);
        lpc_pkg::IDX_ENG3_MAP_CFG:  rdata = 32'(st_r.map[2]);
        default:                    hit   = 1'b0;
      endcase
    end

    // Answer is prepared in the setup cycle so every bus output is a flop
    st_nxt.pready  = i_psel & ~i_penable;
    st_nxt.prdata  = (i_psel & ~i_penable & ~i_pwrite & hit & ~err) ? rdata : 32'h0000_0000;
    st_nxt.pslverr = i_psel & ~i_penable & (~hit | err);

    // Writes land at the access edge that samples pready high
    wr_en = i_psel & i_penable & st_r.pready & i_pwrite & ~st_r.pslverr;
    if (wr_en) begin
      if (idx >= lpc_pkg::IDX_MEM_BASE &&
          idx < lpc_pkg::IDX_MEM_BASE + 8'(lpc_pkg::PAGE_WORDS)) begin
        if (mem_ok) begin
          st_nxt.mem[mem_idx] = i_pwdata[lpc_pkg::WORD_W-1:0];
        end
      end else begin
        case (idx)
          lpc_pkg::IDX_OP_MODE: begin
            st_nxt.mode[0] = i_pwdata[5:4];
            st_nxt.mode[1] = i_pwdata[3:2];
            st_nxt.mode[2] = i_pwdata[1:0];
          end
          lpc_pkg::IDX_CLK_CFG:      st_nxt.ext_sel  = i_pwdata[0];
          lpc_pkg::IDX_VARS:         st_nxt.vars     = i_pwdata;
          lpc_pkg::IDX_ENG1_START:   st_nxt.start[0] = i_pwdata[ADDR_W_L-1:0];
          lpc_pkg::IDX_ENG2_START:   st_nxt.start[1] = i_pwdata[ADDR_W_L-1:0];
          lpc_pkg::IDX_ENG3_START:   st_nxt.start[2] = i_pwdata[ADDR_W_L-1:0];
          lpc_pkg::IDX_PAGE_SEL:     st_nxt.page     = i_pwdata[lpc_pkg::PAGE_W-1:0];
          lpc_pkg::IDX_ENG1_MAP_CFG: st_nxt.map[0]   = i_pwdata[NO-1:0];
          lpc_pkg::IDX_ENG2_MAP_CFG: st_nxt.map[1]   = i_pwdata[NO-1:0];
          lpc_pkg::IDX_ENG3_MAP_CFG: st_nxt.map[2]   = i_pwdata[NO-1:0];
          default: ;
        endcase
      end
    end

    // Engines: each walks its own program independently
    for (int e = 0; e < NE; e++) begin
      tval = d_use_var[e] ? st_r.vars[d_var_time[e]][4:0] : d_time[e];
      ival = d_use_var[e] ? st_r.vars[d_var_val[e]] : d_incr[e];
      pval = d_use_var[e] ? st_r.vars[d_var_val[e]] : d_pwm[e];
      // Step time zero would stall forever, so it counts as one step
      per  = CNT_W_L'(32'((tval == 5'd0) ? 5'd1 : tval) *
                      (d_prescale[e] ? PRESCALE_LONG : PRESCALE_SHORT));
      if (st_r.mode[e] != lpc_pkg::MODE_RUN) begin
        // Leaving run parks the engine at its start address for the next run
        st_nxt.eng[e].pc   = st_r.start[e];
        st_nxt.eng[e].busy = 1'b0;
      end else if (tick) begin
        if (!st_r.eng[e].busy) begin
          st_nxt.eng[e].pc = (32'(st_r.eng[e].pc) >= lpc_pkg::MEM_WORDS - 1) ?
                             '0 : ADDR_W_L'(st_r.eng[e].pc + 1'b1);
          case (d_op[e])
            lpc_pkg::LPC_OP_SETPWM: st_nxt.eng[e].level = pval;
            lpc_pkg::LPC_OP_RAMP, lpc_pkg::LPC_OP_WAIT: begin
              st_nxt.eng[e].busy   = 1'b1;
              st_nxt.eng[e].ramp   = (d_op[e] == lpc_pkg::LPC_OP_RAMP) && (ival != 8'h00);
              st_nxt.eng[e].sign   = d_sign[e];
              st_nxt.eng[e].cnt    = per;
              st_nxt.eng[e].period = per;
              st_nxt.eng[e].steps  = ival;
            end
            default: ;
          endcase
        end else if (st_r.eng[e].cnt > CNT_W_L'(1)) begin
          st_nxt.eng[e].cnt = CNT_W_L'(st_r.eng[e].cnt - 1'b1);
        end else if (st_r.eng[e].ramp) begin
          // Level saturates rather than wrapping at either end
          if (st_r.eng[e].sign) begin
            st_nxt.eng[e].level = (st_r.eng[e].level == '0) ? '0 :
                                  8'(st_r.eng[e].level - 1'b1);
          end else begin
            st_nxt.eng[e].level = (st_r.eng[e].level == lpc_pkg::LEVEL_MAX) ?
                                  lpc_pkg::LEVEL_MAX : 8'(st_r.eng[e].level + 1'b1);
          end
          if (st_r.eng[e].steps <= 8'h01) begin
            st_nxt.eng[e].busy = 1'b0;
          end else begin
            st_nxt.eng[e].steps = 8'(st_r.eng[e].steps - 1'b1);
            st_nxt.eng[e].cnt   = st_r.eng[e].period;
          end
        end else begin
          st_nxt.eng[e].busy = 1'b0;
        end
      end
    end

    // Output levels: only mapped outputs follow an engine, engine one wins ties
    for (int o = 0; o < NO; o++) begin
      st_nxt.out[o] = '0;
      for (int e = NE - 1; e >= 0; e--) begin
        if (st_r.map[e][o]) begin
          st_nxt.out[o] = st_r.eng[e].level;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_prdata    = st_r.prdata;
  assign o_pready    = st_r.pready;
  assign o_pslverr   = st_r.pslverr;
  assign o_out_level = st_r.out;

endmodule // lpc_top

// [test/lpc_top_assertions.sv]
// Purpose: Port-level checks of lpc_top register bus and register shapes
// Assumes: One clock domain, active-low asynchronous reset
// Notes:   Mode and page are snooped from accepted writes
`timescale 1ns/10ps
module lpc_top_chk (
  input  wire logic                        i_clk,
  input  wire logic                        i_rst_n,
  input  wire logic                        i_psel,
  input  wire logic                        i_penable,
  input  wire logic                        i_pwrite,
  input  wire logic [lpc_pkg::PADDR_W-1:0] i_paddr,
  input  wire logic [31:0]                 i_pwdata,
  input  wire logic [31:0]                 o_prdata,
  input  wire logic                        o_pready,
  input  wire logic                        o_pslverr
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic       setup;
  logic       rdsu;
  logic       no_load;
  logic [7:0] idx;
  logic [5:0] mode_r;
  logic [2:0] page_r;
  assign setup = i_psel && !i_penable;
  assign rdsu = setup && !i_pwrite;
  assign idx = i_paddr[9:2];
  assign no_load = mode_r[5:4] != 2'h1 && mode_r[3:2] != 2'h1 && mode_r[1:0] != 2'h1;
  ////////////////////////////////////////////////////////////////////////////////
  // Only accepted writes move the snooped copies, as in the slave
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_r <= 6'h0;
      page_r <= 3'h0;
    end else if (i_psel && i_penable && o_pready && !o_pslverr && i_pwrite) begin
      if (idx == 8'h01) begin
        mode_r <= i_pwdata[5:0];
      end
      if (idx == 8'h4f) begin
        page_r <= i_pwdata[2:0];
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  property p_answer;
    setup |=> o_pready ##1 !o_pready;
  endproperty
  a_answer: assert property (p_answer) else $error("pready not one cycle after setup");
  property p_quiet;
    !o_pready |-> o_prdata == 32'h0 && !o_pslverr;
  endproperty
  a_quiet: assert property (p_quiet) else $error("read data or error outside access");
  property p_unmapped;
    setup && idx == 8'h00 |=> o_pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped index not refused");
  property p_start23;
    rdsu && (idx == 8'h4d || idx == 8'h4e) |=> o_prdata[31:7] == 25'h0;
  endproperty
  a_start23: assert property (p_start23) else $error("start address wider than 7 bits");
  property p_start1;
    rdsu && idx == 8'h4c |=> o_prdata[31:7] == 25'h0;
  endproperty
  a_start1: assert property (p_start1) else $error("engine one start too wide");
  property p_page;
    rdsu && idx == 8'h4f |=> o_prdata[31:3] == 29'h0;
  endproperty
  a_page: assert property (p_page) else $error("page select wider than 3 bits");
  property p_map1;
    rdsu && idx == 8'h70 |=> o_prdata[31:8] == 24'h0 && o_prdata[6:1] == 6'h0;
  endproperty
  a_map1: assert property (p_map1) else $error("map high unused bits set");
  property p_map1l;
    rdsu && idx == 8'h71 |=> o_prdata[31:8] == 24'h0 && !o_pslverr;
  endproperty
  a_map1l: assert property (p_map1l) else $error("map low shape wrong");
  property p_map2;
    rdsu && (idx == 8'h72 || idx == 8'h73) |=> o_prdata[31:8] == 24'h0
      && ($past(idx[0]) || o_prdata[6:1] == 6'h0);
  endproperty
  a_map2: assert property (p_map2) else $error("engine two map shape wrong");
  property p_map3;
    rdsu && (idx == 8'h74 || idx == 8'h75) |=> o_prdata[31:8] == 24'h0
      && ($past(idx[0]) || o_prdata[6:1] == 6'h0);
  endproperty
  a_map3: assert property (p_map3) else $error("engine three map shape wrong");
  property p_gate;
    setup && idx[7:4] == 4'h5 && (no_load || page_r > 3'h5) |=> o_pslverr;
  endproperty
  a_gate: assert property (p_gate) else $error("program word reached outside load");
endmodule // lpc_top_chk

bind lpc_top lpc_top_chk u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr));

// [test/lpc_host_model.sv]
// Purpose: APB host driving the lpc_top registers
// Assumes: Called right after a rising edge; waits for pready, no fixed latency
// Notes:   Released address and data are inverted so stale values cannot pass
`timescale 1ns/10ps
module lpc_host_model (
  input  wire logic        i_clk,
  input  wire logic [31:0] i_prdata,
  input  wire logic        i_pready,
  input  wire logic        i_pslverr,
  output logic             o_psel    = 1'b0,
  output logic             o_penable = 1'b0,
  output logic             o_pwrite  = 1'b0,
  output logic [11:0]      o_paddr   = 12'h0,
  output logic [31:0]      o_pwdata  = 32'h0
);
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    o_psel <= 1'b1;
    o_pwrite <= w;
    o_paddr <= {2'h0, idx, 2'h0};
    o_pwdata <= d;
    @(posedge i_clk);
    o_penable <= 1'b1;
    @(posedge i_clk);
    while (i_pready !== 1'b1) begin
      @(posedge i_clk);
    end
    rd = i_prdata;
    err = i_pslverr;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    o_paddr <= ~o_paddr;
    o_pwdata <= ~o_pwdata;
    @(posedge i_clk);
  endtask
endmodule // lpc_host_model

// [test/testbench.sv]
// Purpose: Self-checking bench for lpc_top registers, memory gating and engines
// Assumes: Short engine tick and prescale parameters
// Notes:   Engines are put on hold before the engine test compares levels; external clock checks compare while engine one runs
`timescale 1ns/10ps
module testbench;
  logic        i_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        i_ext_clk = 1'b0;
  logic        psel, pen, pwr, rdy, err;
  logic [11:0] paddr;
  logic [31:0] pwd, prd;
  logic [79:0] lvl;
  int          n_errors = 0;
  int          checks_done = 0;
  int          cyc = 0;
  lpc_top #(.ENG_DIV(4), .PRESCALE_SHORT(1), .PRESCALE_LONG(2)) uut (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
    .i_pwdata(pwd), .o_prdata(prd), .o_pready(rdy), .o_pslverr(err),
    .i_ext_clk(i_ext_clk), .o_out_level(lvl));
  lpc_host_model host (.i_clk(i_clk), .i_prdata(prd), .i_pready(rdy), .i_pslverr(err),
    .o_psel(psel), .o_penable(pen), .o_pwrite(pwr), .o_paddr(paddr), .o_pwdata(pwd));
  initial begin
    forever #20 i_clk = ~i_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] i, input logic [31:0] d,
                     input logic e, output logic [31:0] r);
    logic g;
    host.xfer(w, i, d, r, g);
    chk("pslverr", {31'h0, g}, {31'h0, e});
  endtask
  task automatic wr(input logic [7:0] i, input logic [31:0] d, input logic e);
    logic [31:0] r;
    acc(1'b1, i, d, e, r);
  endtask
  task automatic mem_wr(input logic [6:0] a, input logic [31:0] w);
    wr(8'h4f, {29'h0, a[6:4]}, 1'b0);
    wr(8'h50 + {4'h0, a[3:0]}, w, 1'b0);
  endtask
  function automatic logic [31:0] set_w(input logic [7:0] v);
    return {16'h0, 8'h40, v};
  endfunction
  function automatic logic [7:0] up3(input logic [7:0] v);
    return (v > 8'hfc) ? 8'hff : v + 8'h3;
  endfunction
  // Hang guard: the whole run needs far fewer cycles
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      stop_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r, v;
    logic [7:0]  a, b, c, i;
    a = $urandom(32'hed54);
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    for (i = 0; i < 4; i++) begin
      acc(1'b0, 8'h4c + i, 0, 1'b0, r);
      chk("start reset", r, 0);
      v = $urandom;
      wr(8'h4c + i, v, 1'b0);
      acc(1'b0, 8'h4c + i, 0, 1'b0, r);
      chk("start rw", r, v & ((i == 3) ? 32'h7 : 32'h7f));
    end
    $display("test start and page done");
    for (i = 0; i < 3; i++) begin
      v = $urandom & 32'h3ff;
      wr(8'h78 + i, v, 1'b0);
      repeat (2) begin
        acc(1'b0, 8'h70 + 2 * i, 0, 1'b0, r);
        chk("map high", r, {24'h0, v[9], 6'h0, v[8]});
        acc(1'b0, 8'h71 + 2 * i, 0, 1'b0, r);
        chk("map low", r, {24'h0, v[7:0]});
        wr(8'h70 + 2 * i, 32'hffffffff, 1'b0);
        wr(8'h71 + 2 * i, 32'h0, 1'b0);
      end
    end
    $display("test mapping done");
    wr(8'h4f, 0, 1'b0);
    wr(8'h50, 32'h4011, 1'b1);
    acc(1'b0, 8'h50, 0, 1'b1, r);
    chk("mem gated", r, 0);
    wr(8'h01, 32'h15, 1'b0);
    wr(8'h4f, 6, 1'b0);
    wr(8'h5f, 32'h1, 1'b1);
    wr(8'h4f, 5, 1'b0);
    v = $urandom & 32'hffff;
    wr(8'h5f, v, 1'b0);
    acc(1'b0, 8'h5f, 0, 1'b0, r);
    chk("last word", r, v);
    $display("test memory done");
    a = 8'hfd;
    b = $urandom;
    c = $urandom;
    wr(8'h4c, 0, 1'b0);
    wr(8'h4d, 32, 1'b0);
    wr(8'h4e, 64, 1'b0);
    wr(8'h78, 32'h1, 1'b0);
    wr(8'h79, 32'h100, 1'b0);
    wr(8'h7a, 32'h200, 1'b0);
    wr(8'h44, {24'h0, c}, 1'b0);
    mem_wr(7'd0, set_w(a));
    mem_wr(7'd1, 32'h0203);
    mem_wr(7'd32, set_w(b));
    mem_wr(7'd64, 32'h8460);
    wr(8'h01, 32'h2a, 1'b0);
    repeat (60) @(posedge i_clk);
    wr(8'h01, 32'h3f, 1'b0);
    chk("out one", lvl[7:0], up3(a));
    chk("out two", lvl[15:8], 0);
    chk("out nine", lvl[71:64], b);
    chk("out general", lvl[79:72], c);
    $display("test engines done");
    wr(8'h36, 1, 1'b0);
    wr(8'h01, 32'h10, 1'b0);
    mem_wr(7'd0, set_w(8'h5a));
    wr(8'h01, 32'h20, 1'b0);
    repeat (40) @(posedge i_clk);
    chk("no ext edge", lvl[7:0], up3(a));
    i_ext_clk <= 1'b1;
    repeat (12) @(posedge i_clk);
    chk("ext edge", lvl[7:0], 8'h5a);
    $display("test external clock done");
    stop_test();
  end
endmodule // testbench
